// File: hdl/chan_sel.sv
`timescale 1ns/1ns
// Notes on behaviour
// - After an init-requested switch, pull requester's interrupt low unless its mask bit 1 set.
// - With init requested, the channel switch happens only after the recovery sequence ends.
// - Downstream interrupt reaches a master's interrupt line unless its mask bit 0 is set.
// - Each master has its own control register at index 1; accesses touch only its copy.
// - Control bit 7 set pulls the other master's interrupt line low.
// - Control bit 6 set pulls the writing master's own interrupt line low.
// - Bit 5 always reads zero; bit 4 is writable and requests bus recovery first.
// - Bits 3 and 1 are read-only copies; bits 2 and 0 are writable.
// - Ownership: equal owner bits mean the reading master owns the channel.
// - Connection: differing connect bits mean upstream and downstream are joined.
// - Selection updates only on a STOP from the master that wrote its control register.
// - When both request, the latest control write before the STOP wins; no arbitration.
// - Pointer write selects the register in its low two bits; with auto-increment set it advances per data byte.
// - Register writes take effect on the rising edge of the ninth clock.
// - Recovery sends nine clocks with data released, then a STOP, downstream.
module chan_sel (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic link_clk_i,
   input wire logic [3:0] addr_pins_i,
   input wire logic [1:0] scl_up_i,
   input wire logic [1:0] sda_up_i,
   output logic [1:0] sda_up_o,
   output logic [1:0] sda_up_oe_o,
   output logic [1:0] irq_b_o,
   input wire logic downstream_irq_b_i,
   output logic [1:0] conn_en_o,
   output logic scl_dn_o,
   output logic scl_dn_oe_o,
   output logic sda_dn_o,
   output logic sda_dn_oe_o
);
   import chan_sel_pkg::*;

   ctrl_wr_t ctrl_q [2];
   logic [3:0] ie_q [2];
   logic [1:0] ie_wr;
   logic [1:0] ctrl_wr;
   logic [1:0] stop_ev;
   logic [1:0][7:0] wr_data;
   logic [3:0] addr_s1, addr_s2;
   logic dn_irq_s1, dn_irq_s2;

   // Read-back image of one master's control register
   function automatic logic [7:0] ctrl_image(input ctrl_wr_t own, input ctrl_wr_t peer, input logic flip);
      logic [7:0] v;
      v = 8'h00;
      v[PEER_IRQ_TEST_BIT] = own.peer_irq_test;
      v[OWN_IRQ_TEST_BIT] = own.own_irq_test;
      v[INIT_REQUEST_BIT] = own.init_request;
      v[PEER_CONNECT_BIT] = peer.own_connect_bit;
      v[OWN_CONNECT_BIT] = own.own_connect_bit;
      // Master 1 sees the peer owner bit inverted so both copies decode one owner
      v[PEER_OWNER_BIT] = peer.own_owner_bit ^ flip;
      v[OWN_OWNER_BIT] = own.own_owner_bit;
      return v;
   endfunction

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_s1 <= 4'h0;
         addr_s2 <= 4'h0;
         dn_irq_s1 <= 1'b1;
         dn_irq_s2 <= 1'b1;
      end else begin
         addr_s1 <= addr_pins_i;
         addr_s2 <= addr_s1;
         dn_irq_s1 <= downstream_irq_b_i;
         dn_irq_s2 <= dn_irq_s1;
      end
   end

   for (genvar m = 0; m < 2; m++) begin : g_up
      logic [2:0] scl_s, sda_s;
      slave_state_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic [1:0] byte_no;
      logic [1:0] ptr;
      logic autoinc;
      logic rw;
      logic drive_low;
      wire scl_rise = scl_s[1] & ~scl_s[2];
      wire scl_fall = ~scl_s[1] & scl_s[2];
      wire start_seen = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
      wire stop_seen = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
      wire addr_hit = shreg[7:1] == {ADDR_PREFIX, addr_s2};
      wire ack_rise = (st == SL_ACK) && scl_rise;
      wire ptr_wr = ack_rise && (byte_no == 2'h1) && !rw;
      wire reg_wr = ack_rise && (byte_no == DATA_BYTE_NO) && !rw;
      wire master_ack = (st == SL_TXACK) && scl_rise && !sda_s[1];
      wire [7:0] ctrl_rd = ctrl_image(ctrl_q[m], ctrl_q[1 - m], 1'(m));
      wire [7:0] rd_byte = (ptr == IE_IDX) ? {4'h0, ie_q[m]} : (ptr == CTRL_IDX) ? ctrl_rd : 8'h00;

      // Each master's strobes reach only its own copy
      assign ie_wr[m] = reg_wr && (ptr == IE_IDX);
      assign ctrl_wr[m] = reg_wr && (ptr == CTRL_IDX);
      assign wr_data[m] = shreg;
      assign stop_ev[m] = stop_seen;
      assign sda_up_o[m] = 1'b0;
      assign sda_up_oe_o[m] = drive_low;

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
         end else begin
            scl_s <= {scl_s[1:0], scl_up_i[m]};
            sda_s <= {sda_s[1:0], sda_up_i[m]};
         end
      end

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            ptr <= IE_IDX;
            autoinc <= 1'b0;
         end else if (ptr_wr) begin
            ptr <= shreg[PTR_IDX_MSB:0];
            autoinc <= shreg[AUTOINC_BIT];
         end else if ((reg_wr || master_ack) && autoinc) begin
            ptr <= ptr + 2'h1;
         end
      end

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            st <= SL_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            byte_no <= 2'h0;
            rw <= 1'b0;
            drive_low <= 1'b0;
         end else if (stop_seen) begin
            st <= SL_IDLE;
            drive_low <= 1'b0;
         end else if (start_seen) begin
            st <= SL_RX;
            bit_cnt <= 4'h0;
            byte_no <= 2'h0;
            drive_low <= 1'b0;
         end else begin
            case (st)
               SL_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s[1]};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                     if (byte_no != 2'h0 || addr_hit) begin
                        st <= SL_ACK;
                        drive_low <= 1'b1;
                        if (byte_no == 2'h0) begin
                           rw <= shreg[0];
                        end
                     end else begin
                        st <= SL_IDLE;
                     end
                  end
               end
               SL_ACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (byte_no != DATA_BYTE_NO) begin
                        byte_no <= byte_no + 2'h1;
                     end
                     if (rw) begin
                        st <= SL_TX;
                        shreg <= rd_byte;
                        drive_low <= ~rd_byte[7];
                     end else begin
                        st <= SL_RX;
                        drive_low <= 1'b0;
                     end
                  end
               end
               SL_TX: begin
                  if (scl_fall) begin
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                        st <= SL_TXACK;
                        drive_low <= 1'b0;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        drive_low <= ~shreg[6];
                     end
                  end
               end
               SL_TXACK: begin
                  if (scl_rise && sda_s[1]) begin
                     st <= SL_IDLE;
                  end else if (scl_fall) begin
                     st <= SL_TX;
                     bit_cnt <= 4'h0;
                     shreg <= rd_byte;
                     drive_low <= ~rd_byte[7];
                  end
               end
               default: begin
                  drive_low <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int m = 0; m < 2; m++) begin
            ie_q[m] <= IE_RST;
            ctrl_q[m] <= CTRL_RST;
         end
      end else begin
         for (int m = 0; m < 2; m++) begin
            if (ie_wr[m]) begin
               ie_q[m] <= wr_data[m][3:0];
            end
            if (ctrl_wr[m]) begin
               ctrl_q[m].peer_irq_test <= wr_data[m][PEER_IRQ_TEST_BIT];
               ctrl_q[m].own_irq_test <= wr_data[m][OWN_IRQ_TEST_BIT];
               ctrl_q[m].init_request <= wr_data[m][INIT_REQUEST_BIT];
               ctrl_q[m].own_connect_bit <= wr_data[m][OWN_CONNECT_BIT];
               ctrl_q[m].own_owner_bit <= wr_data[m][OWN_OWNER_BIT];
            end
         end
      end
   end

   // Selection decoded from both writable copies, so the latest write wins
   sel_t next_sel;
   assign next_sel.on = ctrl_q[0].own_connect_bit ^ ctrl_q[1].own_connect_bit;
   assign next_sel.owner = ctrl_q[0].own_owner_bit ^ ctrl_q[1].own_owner_bit;

   sel_t sel_q, staged_q;
   logic busy, req_m, req_tgl;
   logic [1:0] pending, init_irq;
   logic done_s1, done_s2, done_s3;
   logic done_tgl;
   wire done_ev = done_s2 ^ done_s3;
   wire commit0 = stop_ev[0] && pending[0] && !busy;
   wire commit1 = stop_ev[1] && pending[1] && !busy;
   wire commit = commit0 || commit1;
   wire commit_m = commit1 && !commit0;
   wire want_init = ctrl_q[commit_m].init_request;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
      end else begin
         done_s1 <= done_tgl;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_q <= '0;
         staged_q <= '0;
         busy <= 1'b0;
         req_m <= 1'b0;
         req_tgl <= 1'b0;
         pending <= 2'h0;
         init_irq <= 2'h0;
      end else begin
         for (int m = 0; m < 2; m++) begin
            // A fresh write in the commit cycle keeps its request alive
            if (ctrl_wr[m]) begin
               pending[m] <= 1'b1;
            end else if (m[0] ? commit1 : commit0) begin
               pending[m] <= 1'b0;
            end
            if (done_ev && req_m == m[0]) begin
               init_irq[m] <= 1'b1;
            end else if (ctrl_wr[m]) begin
               init_irq[m] <= 1'b0;
            end
         end
         if (done_ev) begin
            sel_q <= staged_q;
            busy <= 1'b0;
         end else if (commit && want_init) begin
            staged_q <= next_sel;
            sel_q.on <= 1'b0;
            busy <= 1'b1;
            req_m <= commit_m;
            req_tgl <= ~req_tgl;
         end else if (commit) begin
            sel_q <= next_sel;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conn_en_o <= 2'h0;
         irq_b_o <= 2'h3;
      end else begin
         // Drop the join in the commit cycle itself, before the link can start pulsing
         conn_en_o <= (commit && want_init) ? 2'h0 : {sel_q.on & sel_q.owner, sel_q.on & ~sel_q.owner};
         for (int m = 0; m < 2; m++) begin
            irq_b_o[m] <= ~(ctrl_q[m].own_irq_test
               | ctrl_q[1 - m].peer_irq_test
               | (~dn_irq_s2 & ~ie_q[m][DOWNSTREAM_IRQ_MASK_BIT])
               | (init_irq[m] & ~ie_q[m][INIT_DONE_IRQ_MASK_BIT]));
         end
      end
   end

   // Link domain: recovery sequencer, one link cycle per half clock
   link_state_t lst;
   logic [3:0] pulse_cnt;
   logic req_s1, req_s2, req_s3;

   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   assign scl_dn_o = 1'b0;
   assign sda_dn_o = 1'b0;

   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lst <= LK_IDLE;
         pulse_cnt <= 4'h0;
         done_tgl <= 1'b0;
         scl_dn_oe_o <= 1'b0;
         sda_dn_oe_o <= 1'b0;
      end else begin
         case (lst)
            LK_IDLE: begin
               if (req_s2 ^ req_s3) begin
                  lst <= LK_LOW;
                  pulse_cnt <= 4'h0;
                  scl_dn_oe_o <= 1'b1;
               end
            end
            LK_LOW: begin
               lst <= LK_HIGH;
               scl_dn_oe_o <= 1'b0;
               pulse_cnt <= pulse_cnt + 4'h1;
            end
            LK_HIGH: begin
               scl_dn_oe_o <= 1'b1;
               if (pulse_cnt == INIT_PULSES) begin
                  lst <= LK_STOP_LOW;
               end else begin
                  lst <= LK_LOW;
               end
            end
            LK_STOP_LOW: begin
               // Data falls only once the clock is low, so no false START
               lst <= LK_STOP_SCL;
               sda_dn_oe_o <= 1'b1;
            end
            LK_STOP_SCL: begin
               lst <= LK_DONE;
               scl_dn_oe_o <= 1'b0;
            end
            LK_DONE: begin
               lst <= LK_IDLE;
               sda_dn_oe_o <= 1'b0;
               done_tgl <= ~done_tgl;
            end
            default: begin
               lst <= LK_IDLE;
               scl_dn_oe_o <= 1'b0;
               sda_dn_oe_o <= 1'b0;
            end
         endcase
      end
   end

endmodule

// File: hdl/chan_sel_pkg.sv
package chan_sel_pkg;

   // Register indices carried in the low pointer bits
   localparam logic [1:0] IE_IDX = 2'h0;
   localparam logic [1:0] CTRL_IDX = 2'h1;
   localparam int PTR_IDX_MSB = 1;
   localparam int AUTOINC_BIT = 4;

   // Interrupt-mask register fields
   localparam int DOWNSTREAM_IRQ_MASK_BIT = 0;
   localparam int INIT_DONE_IRQ_MASK_BIT = 1;
   localparam logic [3:0] IE_RST = 4'h0;

   // Control register field positions
   localparam int PEER_IRQ_TEST_BIT = 7;
   localparam int OWN_IRQ_TEST_BIT = 6;
   localparam int INIT_REQUEST_BIT = 4;
   localparam int PEER_CONNECT_BIT = 3;
   localparam int OWN_CONNECT_BIT = 2;
   localparam int PEER_OWNER_BIT = 1;
   localparam int OWN_OWNER_BIT = 0;

   // Slave address upper bits; low four come from the address pins
   localparam logic [2:0] ADDR_PREFIX = 3'h7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] DATA_BYTE_NO = 2'h2;

   // Downstream recovery: nine clocks with data released
   localparam logic [3:0] INIT_PULSES = 4'h9;

   // Writable part of a master's control register
   typedef struct packed {
      logic peer_irq_test;
      logic own_irq_test;
      logic init_request;
      logic own_connect_bit;
      logic own_owner_bit;
   } ctrl_wr_t;

   // Power-up state: no channel selected
   localparam ctrl_wr_t CTRL_RST = '{default: 1'b0};

   // Committed downstream selection
   typedef struct packed {
      logic on;
      logic owner;
   } sel_t;

   typedef enum logic [2:0] {
      SL_IDLE,
      SL_RX,
      SL_ACK,
      SL_TX,
      SL_TXACK
   } slave_state_t;

   typedef enum logic [2:0] {
      LK_IDLE,
      LK_LOW,
      LK_HIGH,
      LK_STOP_LOW,
      LK_STOP_SCL,
      LK_DONE
   } link_state_t;

endpackage

// File: verif/chan_sel_chk.sv
`timescale 1ns/1ns
module chan_sel_chk (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic link_clk_i,
   input wire logic [1:0] scl_up_i,
   input wire logic [1:0] sda_up_i,
   input wire logic [1:0] sda_up_o,
   input wire logic [1:0] sda_up_oe_o,
   input wire logic [1:0] irq_b_o,
   input wire logic [1:0] conn_en_o,
   input wire logic scl_dn_o,
   input wire logic scl_dn_oe_o,
   input wire logic sda_dn_o,
   input wire logic sda_dn_oe_o
);
   logic [1:0] scl_q;
   logic [1:0] sda_q;
   logic [5:0] since_stop;
   // Raw pins, so this sees the STOP before the design's synchronisers do
   wire stop_seen = |(scl_q & scl_up_i & sda_up_i & ~sda_q);
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q <= 2'h3;
         sda_q <= 2'h3;
         since_stop <= 6'h3f;
      end else begin
         scl_q <= scl_up_i;
         sda_q <= sda_up_i;
         since_stop <= stop_seen ? 6'h0 : since_stop + {5'h0, since_stop != 6'h3f};
      end
   end
   conn_onehot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) $onehot0(conn_en_o))
      else $error("both masters joined");
   reset_quiet_a: assert property (@(posedge clk_i) !rst_b_i |-> irq_b_o == 2'h3 && conn_en_o == 2'h0)
      else $error("outputs active in reset");
   open_drain_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) !sda_up_o && !scl_dn_o && !sda_dn_o)
      else $error("open drain driven high");
   up0_scl_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $changed(sda_up_oe_o[0]) |-> !scl_up_i[0])
      else $error("data changed with clock high on bus 0");
   up1_scl_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $changed(sda_up_oe_o[1]) |-> !scl_up_i[1])
      else $error("data changed with clock high on bus 1");
   commit_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $changed(conn_en_o) |-> since_stop <= 6'h1e)
      else $error("selection moved without a STOP");
   recovery_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) scl_dn_oe_o |-> conn_en_o == 2'h0)
      else $error("channel joined during recovery");
   dn_stop_seq_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
      $fell(sda_dn_oe_o) |-> !scl_dn_oe_o)
      else $error("recovery data released with clock low");
   cover property (@(posedge clk_i) conn_en_o == 2'h1);
   cover property (@(posedge clk_i) conn_en_o == 2'h2);
   cover property (@(posedge link_clk_i) $rose(scl_dn_oe_o));
endmodule
bind chan_sel chan_sel_chk chk (.clk_i, .rst_b_i, .link_clk_i, .scl_up_i, .sda_up_i, .sda_up_o, .sda_up_oe_o,
   .irq_b_o, .conn_en_o, .scl_dn_o, .scl_dn_oe_o, .sda_dn_o, .sda_dn_oe_o);

// File: verif/i2c_masters.sv
`timescale 1ns/1ns
module i2c_masters #(parameter int Q = 12) (
   input wire logic clk_i,
   input wire logic [1:0] dev_oe_i,
   output logic [1:0] scl_o,
   output logic [1:0] sda_w_o
);
   logic [1:0] sda_drv = 2'h3;
   initial scl_o = 2'h3;
   // Pull-up wire; no clock stretching, so SCL is ours alone
   assign sda_w_o = sda_drv & ~dev_oe_i;
   task automatic q();
      repeat (Q) @(posedge clk_i);
   endtask
   task automatic start(input int m);
      sda_drv[m] <= 1'b1;
      q();
      scl_o[m] <= 1'b1;
      q();
      sda_drv[m] <= 1'b0;
      q();
      scl_o[m] <= 1'b0;
      q();
   endtask
   // Eight bits then the acknowledge slot, MSB first
   task automatic xfer(input int m, input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         sda_drv[m] <= d[i];
         q();
         scl_o[m] <= 1'b1;
         q();
         r[i] = sda_w_o[m];
         q();
         scl_o[m] <= 1'b0;
         q();
      end
   endtask
   task automatic stop(input int m);
      sda_drv[m] <= 1'b0;
      q();
      scl_o[m] <= 1'b1;
      q();
      sda_drv[m] <= 1'b1;
      q();
   endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
   import chan_sel_pkg::*;
   logic clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_b_i = 1'b1;
   logic dn_irq_b = 1'b1;
   logic [3:0] pins;
   logic [1:0] scl, sda, sda_oe, irq_b, conn, sel_exp, pend, done;
   logic scl_oe, sda_oe_dn;
   logic [7:0] w [2];
   logic [7:0] msk [2];
   int n_errors = 0;
   int comparisons = 0;
   int pulses;
   bit dn_stop;
   wire scl_dn = ~scl_oe;
   wire sda_dn = ~sda_oe_dn;
   always #50 clk_i = ~clk_i;
   always #24 link_clk_i = ~link_clk_i;
   // Downstream pull-ups: count clocks sent with data released, then the STOP
   always @(posedge scl_dn) if (sda_dn) pulses++;
   always @(posedge sda_dn) if (scl_dn) dn_stop = 1'b1;
   chan_sel DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .addr_pins_i(pins),
      .scl_up_i(scl), .sda_up_i(sda), .sda_up_o(), .sda_up_oe_o(sda_oe), .irq_b_o(irq_b),
      .downstream_irq_b_i(dn_irq_b), .conn_en_o(conn), .scl_dn_o(), .scl_dn_oe_o(scl_oe),
      .sda_dn_o(), .sda_dn_oe_o(sda_oe_dn));
   i2c_masters #(.Q(12)) mst (.clk_i(clk_i), .dev_oe_i(sda_oe), .scl_o(scl), .sda_w_o(sda));
   function automatic logic [7:0] rd_ctl(input int m);
      return {w[m][7:6], 1'b0, w[m][4], w[1 - m][2], w[m][2], m ? ~w[0][0] : w[1][0], w[m][0]};
   endfunction
   function automatic logic [1:0] conn_of();
      return (w[0][2] ^ w[1][2]) ? ((w[0][0] ^ w[1][0]) ? 2'h2 : 2'h1) : 2'h0;
   endfunction
   function automatic logic [1:0] irq_of();
      logic [1:0] r;
      for (int k = 0; k < 2; k++)
         r[k] = ~(w[k][6] | w[1 - k][7] | (~dn_irq_b & ~msk[k][0]) | (done[k] & ~msk[k][1]));
      return r;
   endfunction
   // Byte that makes the reader own a live channel
   function automatic logic [7:0] take(input logic [7:0] v);
      return {5'h0, ~v[3], 1'b0, v[1]};
   endfunction
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic settle();
      int i;
      for (i = 0; i < 300 && conn !== sel_exp; i++) @(posedge clk_i);
      if (i == 300) begin
         n_errors++;
         $display("mismatch at %0t: selection never settled", $time);
         close_out();
      end
      `CHK(conn, sel_exp)
   endtask
   task automatic fin(input int m);
      mst.stop(m);
      if (pend[m]) begin
         pend[m] = 1'b0;
         sel_exp = conn_of();
         if (w[m][4]) done[m] = 1'b1;
      end
      settle();
      repeat (3) @(posedge clk_i);
      `CHK(irq_b, irq_of())
   endtask
   task automatic wr(input int m, input logic [7:0] p, input logic [15:0] d, input int n, input bit st);
      logic [8:0] r;
      logic [1:0] ix;
      ix = p[1:0];
      mst.start(m);
      mst.xfer(m, {3'h7, pins, 2'h1}, r);
      `CHK(r[0], 1'b0)
      mst.xfer(m, {p, 1'b1}, r);
      `CHK(r[0], 1'b0)
      for (int i = 0; i < n; i++) begin
         mst.xfer(m, {d[15 - 8 * i -: 8], 1'b1}, r);
         `CHK(r[0], 1'b0)
         if (ix == IE_IDX) msk[m] = d[15 - 8 * i -: 8] & 8'h0f;
         if (ix == CTRL_IDX) begin
            w[m] = d[15 - 8 * i -: 8] & 8'hd5;
            pend[m] = 1'b1;
            done[m] = 1'b0;
         end
         if (p[AUTOINC_BIT]) ix++;
      end
      if (st) fin(m);
   endtask
   task automatic rd(input int m, input logic [1:0] ix, output logic [7:0] v);
      logic [8:0] r;
      wr(m, {6'h0, ix}, 16'h0, 0, 0);
      mst.start(m);
      mst.xfer(m, {3'h7, pins, 2'h3}, r);
      mst.xfer(m, 9'h1ff, r);
      v = r[8:1];
      fin(m);
   endtask
   task automatic chk_ctl();
      logic [7:0] v;
      for (int m = 0; m < 2; m++) begin
         rd(m, CTRL_IDX, v);
         `CHK(v, rd_ctl(m))
      end
   endtask
   initial begin
      int m;
      logic [7:0] v;
      logic [8:0] r;
      rst_b_i <= 1'b0;
      void'($urandom(32'hfdd2a927));
      pins = 4'($urandom);
      w = '{8'h0, 8'h0};
      msk = '{8'h0, 8'h0};
      {sel_exp, pend, done} = 6'h0;
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      `CHK(irq_b, 2'h3)
      chk_ctl();
      rd(1, IE_IDX, v);
      `CHK(v, 8'h00)
      rd(0, 2'h2, v);
      `CHK(v, 8'h00)
      for (int i = 0; i < 6; i++) begin
         m = $urandom % 2;
         dn_irq_b <= 1'($urandom);
         wr(m, 8'h10, {8'($urandom), 8'($urandom) & 8'hef}, 2, 1);
         rd(m, IE_IDX, v);
         `CHK(v, msk[m])
         chk_ctl();
      end
      // Overlapping requests: only the writer's own STOP commits
      wr(1, 8'h01, {take(rd_ctl(1)), 8'h0}, 1, 1);
      wr(0, 8'h01, {take(rd_ctl(0)), 8'h0}, 1, 0);
      rd(1, CTRL_IDX, v);
      `CHK(conn, 2'h2)
      wr(1, 8'h01, {take(v), 8'h0}, 1, 0);
      fin(0);
      `CHK(conn, 2'h2)
      fin(1);
      pulses = 0;
      dn_stop = 1'b0;
      wr(0, 8'h10, {8'h00, take(rd_ctl(0)) | 8'h10}, 2, 1);
      `CHK(pulses, 9)
      `CHK(dn_stop, 1'b1)
      `CHK(conn, 2'h1)
      wr(0, 8'h00, 16'h0200, 1, 1);
      mst.start(1);
      mst.xfer(1, {3'h7, ~pins, 2'h1}, r);
      `CHK(r[0], 1'b1)
      mst.stop(1);
      close_out();
   end
endmodule
